// ### src/hb_protect_pkg.sv
// constants, pin indices and register map of the half-bridge protection block
// assumes a single 200 MHz clock and external comparators for temperature, supply and current
package hb_protect_pkg;

  // -----------------------------------------------------------------
  // documented levels, evaluated by the external comparators
  // -----------------------------------------------------------------
  localparam int WARN_TEMP_C       = 125;
  localparam int SHUTDOWN_TEMP_C   = 150;
  localparam int POR_SUPPLY_MV     = 9800;

  // -----------------------------------------------------------------
  // synchronised pin vector layout
  // -----------------------------------------------------------------
  localparam int NUM_BRIDGES       = 3;
  localparam int PIN_PWM           = 0;
  localparam int PIN_RESET_N       = 3;
  localparam int PIN_HS_OC         = 6;
  localparam int PIN_LS_OC         = 9;
  localparam int PIN_GATE_LOW      = 12;
  localparam int PIN_LOGIC_LOW     = 15;
  localparam int PIN_TEMP_WARN     = 16;
  localparam int PIN_TEMP_SD       = 17;
  localparam int PIN_WIDTH         = 18;
  // supplies read as low until the synchroniser has seen the pins
  localparam logic [17:0] PIN_INIT = 18'h0f000;

  // -----------------------------------------------------------------
  // register map (byte addresses) and fields
  // -----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam int CTRL_MODE_BIT         = 0;
  localparam logic CTRL_MODE_RESET     = 1'b0;
  localparam int ST_WARN_BIT           = 0;
  localparam int ST_TSD_BIT            = 1;
  localparam int ST_SUPPLY_LOW_BIT     = 2;
  localparam int ST_OC_SD_LSB          = 4;
  localparam int ST_OC_KIND_LSB        = 8;
  localparam int ST_LIMIT_LSB          = 12;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_MHZ               = 200;
  localparam int SHORT_TRIP_NS         = 80;
  localparam int SHORT_TRIP_CYCLES     = (SHORT_TRIP_NS * CLK_MHZ + 999) / 1000;

endpackage

// ### src/pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output moves only when stages two and three agree
module pin_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // pins and filtered result
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  // -----------------------------------------------------------------
  // filter
  // -----------------------------------------------------------------
  always_comb begin
    next_level = level;
    for (int b = 0; b < W; b++) begin
      if (s2[b] == s3[b]) begin
        next_level[b] = s3[b];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1    <= INIT;
      s2    <= INIT;
      s3    <= INIT;
      level <= INIT;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

endmodule // pin_sync

// ### src/half_bridge_fault_protection.sv
// three-channel half-bridge protection and recovery logic with an apb register port
// assumes comparator and controller pins are asynchronous and an apb master on CLK
//
// Design decisions made here: the register offsets and the APB register port.
module half_bridge_fault_protection #(
  parameter int SHORT_CYCLES = hb_protect_pkg::SHORT_TRIP_CYCLES
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // controller pins
  input  wire logic [2:0]  PWM,
  input  wire logic [2:0]  BRIDGE_RESET_N,
  // detector pins
  input  wire logic [2:0]  HS_OC,
  input  wire logic [2:0]  LS_OC,
  input  wire logic [2:0]  GATE_SUPPLY_LOW,
  input  wire logic        LOGIC_SUPPLY_LOW,
  input  wire logic        TEMP_WARN,
  input  wire logic        TEMP_SHUTDOWN,
  // power stage gate commands
  output logic      [2:0]  HS_ON,
  output logic      [2:0]  LS_ON,
  // open-drain alert pins
  output logic             FAULT_N_O,
  output logic             FAULT_N_OE,
  output logic             OVERTEMP_WARNING_N_O,
  output logic             OVERTEMP_WARNING_N_OE
);

  localparam int NB = hb_protect_pkg::NUM_BRIDGES;
  localparam int CW = $clog2(SHORT_CYCLES + 1);

  // a zero count would trip on the first overcurrent sample
  if (SHORT_CYCLES < 1) begin : g_bad_short
    $error("SHORT_CYCLES must be at least one");
  end

  // -----------------------------------------------------------------
  // pin synchronisation
  // -----------------------------------------------------------------
  logic [hb_protect_pkg::PIN_WIDTH-1:0] pins;
  logic [hb_protect_pkg::PIN_WIDTH-1:0] lvl;

  assign pins = {TEMP_SHUTDOWN, TEMP_WARN, LOGIC_SUPPLY_LOW, GATE_SUPPLY_LOW, LS_OC, HS_OC, BRIDGE_RESET_N, PWM};

  pin_sync #(
    .W    (hb_protect_pkg::PIN_WIDTH),
    .INIT (hb_protect_pkg::PIN_INIT)
  ) u_sync (
    .clk   (CLK),
    .rst   (RST),
    .pin   (pins),
    .level (lvl)
  );

  logic [2:0] pwm;
  logic [2:0] rst_n;
  logic [2:0] hs_oc;
  logic [2:0] ls_oc;
  logic       supply_low_guard;
  logic       temp_warn;
  logic       temp_sd;

  assign pwm              = lvl[hb_protect_pkg::PIN_PWM +: NB];
  assign rst_n            = lvl[hb_protect_pkg::PIN_RESET_N +: NB];
  assign hs_oc            = lvl[hb_protect_pkg::PIN_HS_OC +: NB];
  assign ls_oc            = lvl[hb_protect_pkg::PIN_LS_OC +: NB];
  // any gate supply or the logic supply counts
  assign supply_low_guard = |lvl[hb_protect_pkg::PIN_GATE_LOW +: NB] | lvl[hb_protect_pkg::PIN_LOGIC_LOW];
  assign temp_warn        = lvl[hb_protect_pkg::PIN_TEMP_WARN];
  assign temp_sd          = lvl[hb_protect_pkg::PIN_TEMP_SD];

  // -----------------------------------------------------------------
  // edge history of phase and reset levels
  // -----------------------------------------------------------------
  logic [2:0] pwm_d;
  logic [2:0] rst_n_d;
  logic [2:0] pwm_rise;
  logic [2:0] reset_rise;

  always_ff @(posedge CLK) begin
    if (RST) begin
      pwm_d   <= 3'h0;
      rst_n_d <= 3'h0;
    end else begin
      pwm_d   <= pwm;
      rst_n_d <= rst_n;
    end
  end

  assign pwm_rise   = pwm & ~pwm_d;
  assign reset_rise = rst_n & ~rst_n_d;

  // -----------------------------------------------------------------
  // mode register
  // -----------------------------------------------------------------
  logic mode_select_first;
  logic next_mode_select_first;
  logic cycle_limit_mode;
  logic latching_trip_mode;
  logic wr_en;

  assign wr_en              = PSEL & PENABLE & PWRITE;
  assign cycle_limit_mode   = ~mode_select_first;
  assign latching_trip_mode = mode_select_first;

  always_comb begin
    next_mode_select_first = mode_select_first;
    if (wr_en && PADDR == hb_protect_pkg::CTRL_ADDR) begin
      next_mode_select_first = PWDATA[hb_protect_pkg::CTRL_MODE_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_select_first <= hb_protect_pkg::CTRL_MODE_RESET;
    end else begin
      mode_select_first <= next_mode_select_first;
    end
  end

  // -----------------------------------------------------------------
  // latched faults and the all-resets release
  // -----------------------------------------------------------------
  logic       thermal_shutdown;
  logic       next_thermal_shutdown;
  logic [2:0] oc_sd;
  logic [2:0] oc_kind;
  logic [2:0] rose;
  logic       latched_pending;
  logic       clear_all;

  assign latched_pending = thermal_shutdown | |(oc_sd & oc_kind);
  assign clear_all       = latched_pending & (&rose);

  always_comb begin
    // a new trip beats a release in the same cycle
    next_thermal_shutdown = temp_sd | (thermal_shutdown & ~clear_all);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      thermal_shutdown <= 1'b0;
    end else begin
      thermal_shutdown <= next_thermal_shutdown;
    end
  end

  // -----------------------------------------------------------------
  // per-bridge protection
  // -----------------------------------------------------------------
  logic [2:0] limit_ls;
  logic [2:0] limit_hs;
  logic [2:0] hs_cmd;
  logic [2:0] ls_cmd;

  for (genvar i = 0; i < NB; i++) begin : g_bridge
    logic          lim_ls;
    logic          lim_hs;
    logic          sd;
    logic          kind;
    logic          rs;
    logic [CW-1:0] cnt;
    logic          next_lim_ls;
    logic          next_lim_hs;
    logic          next_sd;
    logic          next_kind;
    logic          next_rs;
    logic [CW-1:0] next_cnt;
    logic          oc_now;
    logic          sd_set;
    logic          sd_clr;
    logic          enable;

    assign oc_now = hs_oc[i] | ls_oc[i];

    always_comb begin
      next_cnt    = '0;
      next_lim_ls = lim_ls;
      next_lim_hs = lim_hs;
      sd_set      = 1'b0;
      if (cycle_limit_mode && rst_n[i]) begin
        // hold until the next phase cycle starts
        if (pwm_rise[i]) begin
          next_lim_ls = 1'b0;
          next_lim_hs = 1'b0;
        end
        if (ls_oc[i]) begin
          next_lim_ls = 1'b1;
        end
        if (hs_oc[i]) begin
          next_lim_hs = 1'b1;
        end
        // overcurrent that limiting cannot hold back is treated as a short
        if (oc_now) begin
          next_cnt = (cnt == CW'(SHORT_CYCLES)) ? cnt : cnt + CW'(1);
        end
        sd_set = oc_now && (cnt == CW'(SHORT_CYCLES - 1));
      end else begin
        next_lim_ls = 1'b0;
        next_lim_hs = 1'b0;
        if (latching_trip_mode && oc_now) begin
          sd_set = 1'b1;
        end
      end
      // own reset rise for a cycle-limit trip, all resets for a latched one
      sd_clr  = kind ? clear_all : reset_rise[i];
      if (supply_low_guard) begin
        sd_clr = 1'b1;
      end
      next_sd   = sd_set | (sd & ~sd_clr);
      next_kind = sd_set ? latching_trip_mode : (next_sd & kind);
      next_rs   = latched_pending & (reset_rise[i] | (rs & ~clear_all));
    end

    always_ff @(posedge CLK) begin
      if (RST) begin
        lim_ls <= 1'b0;
        lim_hs <= 1'b0;
        sd     <= 1'b0;
        kind   <= 1'b0;
        rs     <= 1'b0;
        cnt    <= '0;
      end else begin
        lim_ls <= next_lim_ls;
        lim_hs <= next_lim_hs;
        sd     <= next_sd;
        kind   <= next_kind;
        rs     <= next_rs;
        cnt    <= next_cnt;
      end
    end

    // the bridge runs only with its own reset high, no supply or thermal shutdown and no overcurrent shutdown of its own
    assign enable    = rst_n[i] & ~supply_low_guard & ~thermal_shutdown & ~sd;
    assign hs_cmd[i] = enable & pwm[i] & ~lim_ls & ~lim_hs;
    assign ls_cmd[i] = enable & ((~pwm[i] & ~lim_ls) | lim_hs);
    assign oc_sd[i]  = sd;
    assign oc_kind[i] = kind;
    assign rose[i]   = rs;
    assign limit_ls[i] = lim_ls;
    assign limit_hs[i] = lim_hs;
  end

  // -----------------------------------------------------------------
  // output stage
  // -----------------------------------------------------------------
  logic [2:0] next_hs_on;
  logic [2:0] next_ls_on;
  logic       next_fault_oe;
  logic       next_warn_oe;

  always_comb begin
    next_hs_on    = hs_cmd;
    next_ls_on    = ls_cmd & ~hs_cmd;
    next_fault_oe = supply_low_guard | thermal_shutdown | |oc_sd;
    next_warn_oe  = temp_warn;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      HS_ON                 <= 3'h0;
      LS_ON                 <= 3'h0;
      FAULT_N_OE            <= 1'b0;
      OVERTEMP_WARNING_N_OE <= 1'b0;
    end else begin
      HS_ON                 <= next_hs_on;
      LS_ON                 <= next_ls_on;
      FAULT_N_OE            <= next_fault_oe;
      OVERTEMP_WARNING_N_OE <= next_warn_oe;
    end
  end

  // open-drain: the pins only ever pull low
  assign FAULT_N_O            = 1'b0;
  assign OVERTEMP_WARNING_N_O = 1'b0;

  // -----------------------------------------------------------------
  // apb read path
  // -----------------------------------------------------------------
  logic [31:0] status;
  logic [31:0] next_prdata;
  logic        mapped;

  always_comb begin
    status = 32'h0;
    status[hb_protect_pkg::ST_WARN_BIT]           = temp_warn;
    status[hb_protect_pkg::ST_TSD_BIT]            = thermal_shutdown;
    status[hb_protect_pkg::ST_SUPPLY_LOW_BIT]     = supply_low_guard;
    status[hb_protect_pkg::ST_OC_SD_LSB +: NB]    = oc_sd;
    status[hb_protect_pkg::ST_OC_KIND_LSB +: NB]  = oc_kind;
    status[hb_protect_pkg::ST_LIMIT_LSB +: NB]    = limit_ls | limit_hs;
  end

  assign mapped  = (PADDR == hb_protect_pkg::CTRL_ADDR) || (PADDR == hb_protect_pkg::STATUS_ADDR);
  assign PREADY  = 1'b1;
  // status is read-only, so writes to it are refused as well
  assign PSLVERR = PSEL & PENABLE & (~mapped | (PWRITE & (PADDR == hb_protect_pkg::STATUS_ADDR)));

  always_comb begin
    next_prdata = PRDATA;
    if (PSEL && !PENABLE && !PWRITE) begin
      if (PADDR == hb_protect_pkg::CTRL_ADDR) begin
        next_prdata = {31'h0, mode_select_first};
      end else if (PADDR == hb_protect_pkg::STATUS_ADDR) begin
        next_prdata = status;
      end else begin
        next_prdata = 32'h0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0;
    end else begin
      PRDATA <= next_prdata;
    end
  end

endmodule // half_bridge_fault_protection

// ### dv/hb_protect_properties.sv
// concurrent checks on the half-bridge protection pins
// assumes the top module ports and a single 200 MHz CLK
module hb_protect_checker #(
  parameter int SHORT_CYCLES = 16
) (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // controller and detector pins
  input wire logic [2:0] PWM,
  input wire logic [2:0] BRIDGE_RESET_N,
  input wire logic [2:0] HS_OC,
  input wire logic [2:0] LS_OC,
  input wire logic [2:0] GATE_SUPPLY_LOW,
  input wire logic       LOGIC_SUPPLY_LOW,
  input wire logic       TEMP_WARN,
  input wire logic       TEMP_SHUTDOWN,
  // gate commands and alert pins
  input wire logic [2:0] HS_ON,
  input wire logic [2:0] LS_ON,
  input wire logic       FAULT_N_O,
  input wire logic       FAULT_N_OE,
  input wire logic       OVERTEMP_WARNING_N_O,
  input wire logic       OVERTEMP_WARNING_N_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ---
  // properties
  // ---
  // eight-cycle windows cover the five-edge pin path
  property p_no_shoot; (HS_ON & LS_ON) == 3'h0; endproperty
  property p_rst_off(int i); (!BRIDGE_RESET_N[i])[*8] |-> !HS_ON[i] && !LS_ON[i]; endproperty
  property p_tsd; TEMP_SHUTDOWN[*8] |-> (HS_ON | LS_ON) == 3'h0 && FAULT_N_OE; endproperty
  property p_uv;
    (LOGIC_SUPPLY_LOW || GATE_SUPPLY_LOW != 3'h0)[*8] |-> (HS_ON | LS_ON) == 3'h0 && FAULT_N_OE;
  endproperty
  property p_warn; TEMP_WARN[*8] |-> OVERTEMP_WARNING_N_OE; endproperty
  property p_od; !FAULT_N_O && !OVERTEMP_WARNING_N_O; endproperty
  // a fault that outlives good supplies with resets high holds until its bridge reset rises, or every bridge reset for a latched or thermal trip
  property p_latched;
    (FAULT_N_OE && BRIDGE_RESET_N == 3'h7 && !LOGIC_SUPPLY_LOW && GATE_SUPPLY_LOW == 3'h0)[*8] |=> FAULT_N_OE;
  endproperty
  property p_ls_trip; LS_OC[1][*4] |-> ##[0:5] (!LS_ON[1] && !HS_ON[1]); endproperty
  property p_hs_trip; HS_OC[0][*4] |-> ##[0:5] !HS_ON[0]; endproperty
  property p_follow;
    $rose(PWM[2]) && BRIDGE_RESET_N[2] ##1 (PWM[2] && BRIDGE_RESET_N[2] && !FAULT_N_OE)[*7] |-> HS_ON[2];
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both transistors on");
  a_rst_off: assert property (p_rst_off(0)) else $error("bridge driven in reset");
  a_tsd: assert property (p_tsd) else $error("hot device still driving");
  a_uv: assert property (p_uv) else $error("low supply still driving");
  a_warn: assert property (p_warn) else $error("warning pin not low");
  a_od: assert property (p_od) else $error("alert pin drives high");
  a_latched: assert property (p_latched) else $error("latched fault released");
  a_ls_trip: assert property (p_ls_trip) else $error("low side not cut");
  a_hs_trip: assert property (p_hs_trip) else $error("high side not cut");
  a_follow: assert property (p_follow) else $error("high side not following");
  c_tsd: cover property (TEMP_SHUTDOWN[*8]);
  c_clear: cover property ($fell(FAULT_N_OE));
  c_trip: cover property (LS_OC[1][*8]);
endmodule // hb_protect_checker

bind half_bridge_fault_protection hb_protect_checker #(.SHORT_CYCLES(SHORT_CYCLES)) u_hb_protect_checker (
  .CLK(CLK), .RST(RST), .PWM(PWM), .BRIDGE_RESET_N(BRIDGE_RESET_N), .HS_OC(HS_OC), .LS_OC(LS_OC),
  .GATE_SUPPLY_LOW(GATE_SUPPLY_LOW), .LOGIC_SUPPLY_LOW(LOGIC_SUPPLY_LOW), .TEMP_WARN(TEMP_WARN),
  .TEMP_SHUTDOWN(TEMP_SHUTDOWN), .HS_ON(HS_ON), .LS_ON(LS_ON), .FAULT_N_O(FAULT_N_O),
  .FAULT_N_OE(FAULT_N_OE), .OVERTEMP_WARNING_N_O(OVERTEMP_WARNING_N_O),
  .OVERTEMP_WARNING_N_OE(OVERTEMP_WARNING_N_OE));

// ### dv/pwm_ctrl_model.sv
// controller model driving phase and bridge reset pins
// assumes the bench changes its commands just after a clock edge
module pwm_ctrl_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench commands
  input  wire logic [2:0] run,
  input  wire logic [2:0] hold,
  input  wire logic [2:0] reset_req_n,
  // controller pins
  output logic      [2:0] pwm,
  output logic      [2:0] bridge_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] phase;
  // ---
  // switching
  // ---
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= 6'h00;
    end else begin
      phase <= phase + 6'h01;
    end
  end
  // low side on 20 cycles (100 ns) each period keeps the bootstrap charged
  assign pwm = (run & {3{phase >= 6'h14}}) | (~run & hold);
  assign bridge_reset_n = reset_req_n;
endmodule // pwm_ctrl_model

// ### dv/half_bridge_fault_protection_test.sv
// self-checking bench for the half-bridge protection block
// assumes the apb slave answers with no wait states
module half_bridge_fault_protection_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CTRL = hb_protect_pkg::CTRL_ADDR;
  localparam logic [11:0] STAT = hb_protect_pkg::STATUS_ADDR;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  run = 3'h0;
  logic [2:0]  hold = 3'h5;
  logic [2:0]  reset_req_n = 3'h7;
  logic [2:0]  hs_oc = 3'h0;
  logic [2:0]  ls_oc = 3'h0;
  logic [2:0]  gate_low = 3'h0;
  logic        logic_low = 1'b0;
  logic        temp_warn = 1'b0;
  logic        temp_sd = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, fault_o, fault_oe, warn_o, warn_oe;
  logic [2:0]  pwm, bridge_reset_n, hs_on, ls_on;
  int          n_mismatch = 0;
  int          total_checks = 0;
  always #2.5 clk = ~clk;
  // short trip count of 8 keeps the shutdown cases brief
  half_bridge_fault_protection #(.SHORT_CYCLES(8)) u_half_bridge_fault_protection (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PWM(pwm),
    .BRIDGE_RESET_N(bridge_reset_n), .HS_OC(hs_oc), .LS_OC(ls_oc), .GATE_SUPPLY_LOW(gate_low),
    .LOGIC_SUPPLY_LOW(logic_low), .TEMP_WARN(temp_warn), .TEMP_SHUTDOWN(temp_sd), .HS_ON(hs_on),
    .LS_ON(ls_on), .FAULT_N_O(fault_o), .FAULT_N_OE(fault_oe), .OVERTEMP_WARNING_N_O(warn_o),
    .OVERTEMP_WARNING_N_OE(warn_oe));
  pwm_ctrl_model u_pwm_ctrl_model (.clk(clk), .rst(rst), .run(run), .hold(hold),
    .reset_req_n(reset_req_n), .pwm(pwm), .bridge_reset_n(bridge_reset_n));
  // ---
  // tasks
  // ---
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // sample away from the edge that launches the registered outputs
  task automatic pins(input logic [7:0] exp);
    @(negedge clk);
    chk({24'h0, hs_on, ls_on, fault_oe, warn_oe}, {24'h0, exp});
    @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, err});
  endtask
  task automatic pulse(input logic [2:0] m);
    reset_req_n <= ~m;
    w(8);
    reset_req_n <= 3'h7;
    w(10);
  endtask
  task automatic oc(input logic [5:0] v, input int n);
    {hs_oc, ls_oc} <= v;
    w(n);
    {hs_oc, ls_oc} <= 6'h0;
    w(10);
  endtask
  // in cycle-limit mode with the bridge reset high, only a fresh phase rise lifts a current limit
  task automatic kick(input logic [2:0] m);
    hold <= 3'h5 ^ m;
    w(10);
    hold <= 3'h5;
    w(10);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---
  // sequence
  // ---
  initial begin
    w(8);
    rst <= 1'b0;
    w(12);
    pins(8'b101_010_00);
    rd(CTRL, 32'hffffffff, 32'h0, 1'b0);
    wr(CTRL, 32'h1, 1'b0);
    rd(CTRL, 32'h1, 32'h1, 1'b0);
    wr(CTRL, 32'h0, 1'b0);
    rd(12'h008, 32'hffffffff, 32'h0, 1'b1);
    wr(STAT, 32'h7, 1'b1);
    run <= 3'h7;
    w(200);
    run <= 3'h0;
    w(12);
    pins(8'b101_010_00);
    reset_req_n <= 3'h6;
    w(10);
    pins(8'b100_010_00);
    reset_req_n <= 3'h7;
    temp_warn <= 1'b1;
    w(10);
    pins(8'b101_010_01);
    temp_warn <= 1'b0;
    temp_sd <= 1'b1;
    w(10);
    pins(8'b000_000_10);
    rd(STAT, 32'h2, 32'h2, 1'b0);
    temp_sd <= 1'b0;
    w(10);
    pins(8'b000_000_10);
    pulse(3'h1);
    pulse(3'h2);
    pins(8'b000_000_10);
    pulse(3'h4);
    pins(8'b101_010_00);
    for (int k = 0; k < 4; k++) begin
      {logic_low, gate_low} <= 4'(1 << k);
      w(10);
      pins(8'b000_000_10);
      {logic_low, gate_low} <= 4'h0;
      w(10);
      pins(8'b101_010_00);
    end
    oc(6'h02, 4);
    pins(8'b101_000_00);
    kick(3'h2);
    pins(8'b101_010_00);
    oc(6'h08, 4);
    pins(8'b100_011_00);
    kick(3'h1);
    oc(6'h02, 20);
    pins(8'b101_000_10);
    rd(STAT, 32'h770, 32'h20, 1'b0);
    pulse(3'h1);
    pins(8'b101_000_10);
    pulse(3'h2);
    kick(3'h2);
    pins(8'b101_010_00);
    wr(CTRL, 32'h1, 1'b0);
    oc(6'h02, 4);
    pins(8'b101_000_10);
    rd(STAT, 32'h770, 32'h220, 1'b0);
    pulse(3'h2);
    pins(8'b101_000_10);
    pulse(3'h7);
    pins(8'b101_010_00);
    wr(CTRL, 32'h0, 1'b0);
    oc(6'h02, 20);
    logic_low <= 1'b1;
    w(10);
    logic_low <= 1'b0;
    w(10);
    kick(3'h2);
    pins(8'b101_010_00);
    summarize();
  end
  initial begin
    w(20000);
    n_mismatch++;
    summarize();
  end
endmodule // half_bridge_fault_protection_test
